/* File: design/mgmt_bank_pkg.sv */
/*
  Shared constants for the management register bank: geometry, per-register
  access masks, reset values and the pin-strapped field.
  Assumes a 16-bit data field per register and five-bit register addresses.
*/
package mgmt_bank_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  localparam int PIN_N = 5;
  localparam logic [ADDR_W-1:0] RSVD_LO = 5'h09;
  localparam logic [ADDR_W-1:0] RSVD_HI = 5'h0F;
  localparam logic [REG_W-1:0] ABSENT_VAL = 16'hFFFF;

  // ************************************************************
  // Override control and pin-strapped field
  // ************************************************************
  localparam logic [ADDR_W-1:0] OVR_REG = 5'h10;
  localparam int OVR_BIT = 15;
  localparam logic [ADDR_W-1:0] PIN_REG = 5'h10;
  localparam int PIN_LSB = 0;
  localparam logic [REG_W-1:0] PIN_MASK = 16'h001F;

  // ************************************************************
  // Strap capture states, Gray coded along the path
  // ************************************************************
  typedef enum logic [1:0]
  {
    STRAP_WAIT = 2'b00,
    STRAP_LOAD = 2'b01,
    STRAP_DONE = 2'b11
  } strap_e;

  // ************************************************************
  // Per-register masks; index is the register address
  // ************************************************************
  function automatic logic [REG_W-1:0] ro_mask(input logic [ADDR_W-1:0] a);
    case (a)
      5'h00: ro_mask = 16'h007F;
      5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08: ro_mask = 16'hFFFF;
      5'h10: ro_mask = 16'h801F;
      5'h11: ro_mask = 16'hFFFF;
      default: ro_mask = 16'h0000;
    endcase
  endfunction : ro_mask

  function automatic logic [REG_W-1:0] cw_mask(input logic [ADDR_W-1:0] a);
    case (a)
      5'h10: cw_mask = 16'h7000;
      5'h13: cw_mask = 16'h0300;
      default: cw_mask = 16'h0000;
    endcase
  endfunction : cw_mask

  function automatic logic [REG_W-1:0] w0_mask(input logic [ADDR_W-1:0] a);
    case (a)
      5'h12: w0_mask = 16'h8000;
      default: w0_mask = 16'h0000;
    endcase
  endfunction : w0_mask

  function automatic logic [REG_W-1:0] rst_val(input logic [ADDR_W-1:0] a);
    case (a)
      5'h00: rst_val = 16'h3000;
      5'h04: rst_val = 16'h01E1;
      5'h10: rst_val = 16'h0000;
      5'h12: rst_val = 16'h8000;
      default: rst_val = 16'h0000;
    endcase
  endfunction : rst_val

endpackage : mgmt_bank_pkg

/* File: design/mgmt_reg_access_policy.sv */
/*
  Management register bank with per-bit access policy and strapped defaults.
  Assumes a frame decoder on ref_clk issues one-cycle read and write strobes.
*/
// What this block does
// (RULE1) Read-only bits read back their value; writes to them are dropped.
// (RULE2) Protected bits always readable; writes ignored while override bit is zero.
// (RULE3) With override set, the next register write updates protected bits.
// (RULE4) Override bit clears itself once that next register write completes.
// (RULE5) Plain read/write bits store every write and read back unconditionally.
// (RULE6) Write-zero-only bits accept a zero; writing a one changes nothing.
// (RULE7) Reset loads every bit that has a default with that default.
// (RULE8) Pin-dependent bits take the level sampled on their pin at reset.
// (RULE9) Bits without a default need no particular reset level.
// (RULE10) The far side must leave reserved test bits at their defaults.
// (RULE11) Every register is sixteen bits, one frame data field wide.
`timescale 1ns/1ps
module mgmt_reg_access_policy
  import mgmt_bank_pkg::*;
#(
  parameter int NUM_REGS = 20
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0] wr_data,
  input wire logic addr0_activity_led_pin,
  input wire logic addr1_collision_led_pin,
  input wire logic addr2_link_led_pin,
  input wire logic addr3_transmit_led_pin,
  input wire logic addr4_receive_led_pin,
  output logic [REG_W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic override_q,
  output logic strap_done_q,
  output logic [REG_W-1:0] ctrl_q,
  output logic [REG_W-1:0] ext_ctrl_q
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [2:0] fill_q;
  logic pins_settled;

  assign pin_raw = {addr4_receive_led_pin, addr3_transmit_led_pin, addr2_link_led_pin,
                    addr1_collision_led_pin, addr0_activity_led_pin};

  // Three stages; only the second and third are compared
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      fill_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // The third stage holds reset zeros, not pins, until three edges have passed
  assign pins_settled = fill_q[2] && (s2_q == s3_q); // RULE8

  // ************************************************************
  // Strap capture after reset release
  // ************************************************************
  strap_e strap_q;

  // Pins are caught after release, never under the async reset itself
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      strap_q <= STRAP_WAIT;
    else if (ce)
    begin
      case (strap_q)
        STRAP_WAIT: if (pins_settled) strap_q <= STRAP_LOAD;
        STRAP_LOAD: strap_q <= STRAP_DONE;
        STRAP_DONE: strap_q <= STRAP_DONE;
        default: strap_q <= STRAP_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      strap_done_q <= 1'b0;
    else if (ce && strap_q == STRAP_LOAD)
      strap_done_q <= 1'b1;
  end

  // ************************************************************
  // Access decode
  // ************************************************************
  logic [REG_W-1:0] bank_q [0:NUM_REGS-1];
  logic reg_exists;
  logic wr_go;
  logic rd_go;
  logic [REG_W-1:0] cur_val;
  logic [REG_W-1:0] keep_m;
  logic [REG_W-1:0] take_m;
  logic [REG_W-1:0] merged;

  // Absent and reserved addresses read all ones and swallow writes
  assign reg_exists = (32'(reg_addr) < NUM_REGS) && !(reg_addr >= RSVD_LO && reg_addr <= RSVD_HI);
  assign wr_go = ce && wr_stb && strap_done_q;
  assign rd_go = ce && rd_stb && strap_done_q;
  assign cur_val = reg_exists ? bank_q[reg_addr] : '0;

  // Per-bit merge of old contents and write data
  assign keep_m = ro_mask(reg_addr) | (cw_mask(reg_addr) & {REG_W{~override_q}}); // RULE1 RULE2
  assign take_m = ~(ro_mask(reg_addr) | cw_mask(reg_addr) | w0_mask(reg_addr))
                  | (cw_mask(reg_addr) & {REG_W{override_q}}); // RULE3 RULE5
  assign merged = (cur_val & keep_m) | (wr_data & take_m)
                  | (cur_val & wr_data & w0_mask(reg_addr)); // RULE6

  // ************************************************************
  // Register storage, one process per register
  // ************************************************************
  for (genvar gi = 0; gi < NUM_REGS; gi++)
  begin : g_reg
    localparam logic [ADDR_W-1:0] IDX = ADDR_W'(gi);
    // Bits with no default simply reset to zero; cheaper than a split flop
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
        bank_q[gi] <= rst_val(IDX); // RULE7 RULE9
      else if (ce)
      begin
        if (strap_q == STRAP_LOAD && IDX == PIN_REG)
          bank_q[gi] <= (bank_q[gi] & ~PIN_MASK)
                        | ((REG_W'(s3_q) << PIN_LSB) & PIN_MASK); // RULE8
        else if (wr_go && reg_exists && reg_addr == IDX)
          bank_q[gi] <= merged; // RULE11
      end
    end
  end

  // ************************************************************
  // Command override bit
  // ************************************************************
  // Any completed write while armed disarms it, even one that sets it again
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      override_q <= 1'b0;
    else if (wr_go)
    begin
      if (override_q)
        override_q <= 1'b0; // RULE4
      else if (reg_addr == OVR_REG)
        override_q <= wr_data[OVR_BIT];
    end
  end

  // ************************************************************
  // Read port and mirrored outputs
  // ************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_q <= rd_go;
      if (rd_go)
        rd_data_q <= !reg_exists ? ABSENT_VAL
                   : (reg_addr == OVR_REG) ? (cur_val | (REG_W'(override_q) << OVR_BIT))
                   : cur_val; // RULE1 RULE2 RULE5
    end
  end

  assign ctrl_q = bank_q[0];
  assign ext_ctrl_q = bank_q[OVR_REG];

  // ************************************************************
  // Checking helpers and assertions
  // ************************************************************
  logic last_wr_q;
  logic last_ovr_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic [REG_W-1:0] last_val_q;
  logic [REG_W-1:0] last_data_q;
  logic [REG_W-1:0] now_val;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_wr_q <= 1'b0;
      last_ovr_q <= 1'b0;
      last_addr_q <= '0;
      last_val_q <= '0;
      last_data_q <= '0;
    end
    else if (ce)
    begin
      last_wr_q <= wr_go && reg_exists;
      last_ovr_q <= override_q;
      last_addr_q <= reg_addr;
      last_val_q <= cur_val;
      last_data_q <= wr_data;
    end
  end

  assign now_val = bank_q[last_addr_q];

  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  ro_hold_a: assert property (last_wr_q |-> // RULE1
    ((now_val & ro_mask(last_addr_q)) == (last_val_q & ro_mask(last_addr_q))))
    else $error("read-only bits changed by a write");
  cw_block_a: assert property (last_wr_q && !last_ovr_q |-> // RULE2
    ((now_val & cw_mask(last_addr_q)) == (last_val_q & cw_mask(last_addr_q))))
    else $error("protected bits written without override");
  cw_take_a: assert property (last_wr_q && last_ovr_q |-> // RULE3
    ((now_val & cw_mask(last_addr_q)) == (last_data_q & cw_mask(last_addr_q))))
    else $error("protected bits not written under override");
  ovr_clear_a: assert property (ce && wr_go && override_q |=> !override_q) // RULE4
    else $error("override bit did not self clear");
  rw_store_a: assert property (last_wr_q |-> ((now_val & ~(ro_mask(last_addr_q)
    | cw_mask(last_addr_q) | w0_mask(last_addr_q))) == (last_data_q & ~(ro_mask(last_addr_q)
    | cw_mask(last_addr_q) | w0_mask(last_addr_q))))) // RULE5
    else $error("read/write bits did not store write data");
  w0_only_a: assert property (last_wr_q |-> ((now_val & w0_mask(last_addr_q)) // RULE6
    == (last_val_q & last_data_q & w0_mask(last_addr_q))))
    else $error("write-zero-only bit took a one");
  reset_dflt_a: assert property (strap_q == STRAP_WAIT |-> // RULE7
    (bank_q[0] == rst_val(5'h00) && !override_q))
    else $error("defaults not loaded after reset");
  strap_load_a: assert property (ce && strap_q == STRAP_LOAD |=> // RULE8
    ((bank_q[PIN_REG] & PIN_MASK) == ((REG_W'($past(s3_q)) << PIN_LSB) & PIN_MASK)))
    else $error("strapped bits differ from sampled pins");
  rd_answer_a: assert property (rd_go |=> rd_valid_q && // RULE11
    rd_data_q == $past(!reg_exists ? ABSENT_VAL : (reg_addr == OVR_REG)
      ? (cur_val | (REG_W'(override_q) << OVR_BIT)) : cur_val))
    else $error("read answer wrong or late");

endmodule : mgmt_reg_access_policy

/* File: testbench/mgmt_station.sv */
/*
  Station-side model: issues one management access per call.
  Assumes calls come from one bench process, one access at a time.
*/
`timescale 1ns/1ps
module mgmt_station
  import mgmt_bank_pkg::*;
(
  input wire logic ref_clk,
  output logic ce,
  output logic rd_stb,
  output logic wr_stb,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [REG_W-1:0] wr_data
);
  // ****************************************
  // Idle lines at time zero
  // ****************************************
  initial
  begin
    ce = 1'b1;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    reg_addr = '0;
    wr_data = '0;
  end

  // ****************************************
  // One access, held for one edge, then released
  // ****************************************
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [REG_W-1:0] d, input logic c);
    @(posedge ref_clk);
    ce <= c;
    rd_stb <= !wr;
    wr_stb <= wr;
    reg_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    ce <= 1'b1;
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    reg_addr <= ~a; // Released address and data lines never keep the old value
    wr_data <= ~d;
  endtask : access
endmodule : mgmt_station

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the management register bank.
  Assumes the station model drives all request lines.
*/
`timescale 1ns/1ps
module testbench
  import mgmt_bank_pkg::*;
;
  logic ref_clk, arst_n, ce, rd_stb, wr_stb, rd_valid_q, override_q, strap_done_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0] wr_data, rd_data_q, ctrl_q, ext_ctrl_q;
  logic [4:0] pins;
  logic [REG_W-1:0] mem[32];
  logic ovr;
  logic [31:0] lfsr = 32'h50C6;
  logic [4:0] addr_list[8] = '{5'h00, 5'h04, 5'h10, 5'h12, 5'h13, 5'h09, 5'h19, 5'h11};
  int n_mismatch = 0;
  int cmp_count = 0;

  // ****************************************
  // Clock, design and station
  // ****************************************
  always #10 ref_clk = ~ref_clk;
  mgmt_reg_access_policy #(.NUM_REGS(20)) u_mgmt_reg_access_policy (.ref_clk(ref_clk),
    .arst_n(arst_n), .ce(ce), .rd_stb(rd_stb), .wr_stb(wr_stb), .reg_addr(reg_addr),
    .wr_data(wr_data), .addr0_activity_led_pin(pins[0]), .addr1_collision_led_pin(pins[1]),
    .addr2_link_led_pin(pins[2]), .addr3_transmit_led_pin(pins[3]),
    .addr4_receive_led_pin(pins[4]), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .override_q(override_q), .strap_done_q(strap_done_q), .ctrl_q(ctrl_q),
    .ext_ctrl_q(ext_ctrl_q));
  mgmt_station u_mgmt_station (.ref_clk(ref_clk), .ce(ce), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .reg_addr(reg_addr), .wr_data(wr_data));

  // ****************************************
  // Reference model of the bank
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic here(input logic [4:0] a);
    return a < 5'd20 && !(a inside {[RSVD_LO:RSVD_HI]});
  endfunction : here

  function automatic logic [15:0] ro_bits(input logic [4:0] a);
    return (a == 5'h00) ? 16'h007F : (a == 5'h10) ? 16'h801F :
      (a inside {5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h11}) ? 16'hFFFF : 16'h0000;
  endfunction : ro_bits

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One access, model update and compare
  task automatic op(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic c);
    logic [15:0] exp, keep, w0, nv;
    logic armed;
    exp = here(a) ? (mem[a] | ((a == 5'h10 && ovr) ? 16'h8000 : 16'h0000)) : 16'hFFFF;
    u_mgmt_station.access(wr, a, d, c);
    #1;
    if (!wr)
    begin
      chk("rd_valid", {15'h0, rd_valid_q}, {15'h0, c});
      if (c)
        chk("rd_data", rd_data_q, exp);
    end
    else if (c)
    begin
      armed = ovr;
      keep = ro_bits(a) | (armed ? 16'h0 : (a == 5'h10 ? 16'h7000 : a == 5'h13 ? 16'h0300 : 16'h0));
      w0 = (a == 5'h12) ? 16'h8000 : 16'h0000;
      nv = (mem[a] & keep) | (d & ~keep);
      nv = (nv & ~w0) | (mem[a] & d & w0);
      if (here(a))
        mem[a] = nv;
      ovr = !armed && a == 5'h10 && d[15];
    end
    chk("override", {15'h0, override_q}, {15'h0, ovr});
    chk("ctrl", ctrl_q, mem[0]);
    chk("ext_ctrl", ext_ctrl_q, mem[16] & 16'h7FFF);
  endtask : op

  // Reset with given strap levels; defaults loaded into the model
  task automatic do_reset(input logic [4:0] p);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    pins <= p;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk("strap_done", {15'h0, strap_done_q}, 16'h0001);
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[0] = 16'h3000;
    mem[4] = 16'h01E1;
    mem[18] = 16'h8000;
    mem[16] = {11'h0, p};
    ovr = 1'b0;
    for (int i = 0; i < 32; i++) op(1'b0, 5'(i), 16'h0, 1'b1);
    $display("test reset defaults done");
  endtask : do_reset

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    logic [31:0] r;
    logic [15:0] d;
    ref_clk = 1'b0;
    arst_n = 1'b0;
    pins = 5'h00;
    do_reset(5'(rnd()));
    op(1'b1, 5'h10, 16'h7000, 1'b1);
    op(1'b1, 5'h10, 16'h8000, 1'b1);
    op(1'b1, 5'h13, 16'h0300, 1'b1);
    op(1'b0, 5'h13, 16'h0000, 1'b1);
    op(1'b1, 5'h12, 16'h8000, 1'b1);
    op(1'b1, 5'h12, 16'h0000, 1'b1);
    op(1'b1, 5'h12, 16'hFFFF, 1'b1);
    op(1'b0, 5'h12, 16'h0000, 1'b1);
    $display("test override and write-zero done");
    repeat (300)
    begin
      r = rnd();
      d = 16'(rnd());
      if (addr_list[r[2:0]] == 5'h00)
        d[6:0] = 7'h00;
      op(r[3], addr_list[r[2:0]], d, r[7:4] != 4'h0);
    end
    $display("test random traffic done");
    do_reset(~pins);
    conclude();
  end

  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench
